// ===== rtl/lp_mem_pkg.sv
// shared types, timing constants and command codes for both ends of the memory link
// assumes a single 25 MHz reference clock shared by controller and device
package lp_mem_pkg;
    localparam int CLK_MHZ = 25;
    localparam int NS_ROUND = 999;
    localparam int NS_PER_US = 1000;
    // times in ns; least times rounded up to whole cycles
    localparam int POWER_DOWN_EXIT_TIME_NS = 8;
    localparam int SELF_REFRESH_EXIT_TIME_NS = 140;
    localparam int PRECHARGE_TIME_NS = 18;
    localparam int ROW_TO_COLUMN_DELAY_NS = 18;
    localparam int REFRESH_PB_TIME_NS = 60;
    localparam int REFRESH_AB_TIME_NS = 130;
    localparam int FINAL_INIT_WAIT_NS = 10000;
    localparam logic [7:0] XP_CYC   = 8'((POWER_DOWN_EXIT_TIME_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] XSR_CYC  = 8'((SELF_REFRESH_EXIT_TIME_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] RP_CYC   = 8'((PRECHARGE_TIME_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] RCD_CYC  = 8'((ROW_TO_COLUMN_DELAY_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] RFPB_CYC = 8'((REFRESH_PB_TIME_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] RFAB_CYC = 8'((REFRESH_AB_TIME_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] INIT_CYC = 8'((FINAL_INIT_WAIT_NS * CLK_MHZ + NS_ROUND) / NS_PER_US);
    localparam logic [7:0] MRR_CYC   = 8'h04;
    localparam logic [7:0] MRW_CYC   = 8'h0a;
    localparam logic [7:0] BURST_CYC = 8'h04;
    localparam logic [7:0] CLK_TOGGLES = 8'h02;
    localparam logic [7:0] T_ZERO = 8'h00;
    localparam logic [7:0] T_ONE  = 8'h01;
    localparam int ROW_W = 15;
    localparam int BANK_W = 3;

    typedef enum logic [3:0] {
        C_NOP       = 4'h0,
        C_ACTIVATE  = 4'h1,
        C_READ      = 4'h2,
        C_WRITE     = 4'h3,
        C_PRECHARGE = 4'h4,
        C_REF_PB    = 4'h5,
        C_REF_AB    = 4'h6,
        C_MRW       = 4'h7,
        C_MRW_RESET = 4'h8,
        C_MRR       = 4'h9,
        C_RESET     = 4'ha,
        C_SREF      = 4'hb,
        C_DEEP      = 4'hc,
        C_ENTER_PD  = 4'hd,
        C_EXIT_LP   = 4'he
    } cmd_type;

    typedef enum logic [7:0] {
        P_POWER_ON  = 8'h01,
        P_RESETTING = 8'h02,
        P_OPERATING = 8'h04,
        P_PD_ACTIVE = 8'h08,
        P_PD_IDLE   = 8'h10,
        P_PD_RESET  = 8'h20,
        P_SREF      = 8'h40,
        P_DEEP      = 8'h80
    } pwr_type;

    typedef enum logic [11:0] {
        B_IDLE       = 12'h001,
        B_ACTIVATING = 12'h002,
        B_ACTIVE     = 12'h004,
        B_READ       = 12'h008,
        B_WRITE      = 12'h010,
        B_PRECH      = 12'h020,
        B_REF_PB     = 12'h040,
        B_REF_AB     = 12'h080,
        B_MRW        = 12'h100,
        B_MRR_IDLE   = 12'h200,
        B_MRR_ACT    = 12'h400,
        B_MRR_RST    = 12'h800
    } bank_type;

    // cycles a command keeps the bank in its timed state; the reset commands give the initialization wait
    function automatic logic [7:0] cmd_cycles(input cmd_type c);
        unique case (c)
            C_ACTIVATE:          cmd_cycles = RCD_CYC;
            C_READ, C_WRITE:     cmd_cycles = BURST_CYC;
            C_PRECHARGE:         cmd_cycles = RP_CYC;
            C_REF_PB:            cmd_cycles = RFPB_CYC;
            C_REF_AB:            cmd_cycles = RFAB_CYC;
            C_MRW:               cmd_cycles = MRW_CYC;
            C_MRR:               cmd_cycles = MRR_CYC;
            C_RESET, C_MRW_RESET: cmd_cycles = INIT_CYC;
            default:             cmd_cycles = T_ZERO;
        endcase
    endfunction
endpackage

// ===== rtl/lp_mem_link_if.sv
// link between memory controller and memory device
// assumes both ends run on the same rising clock edge
`timescale 1ns/1ps
`default_nettype none
interface lp_mem_link_if;
    import lp_mem_pkg::*;
    logic                    cke;
    logic                    cs_n;
    cmd_type                 cmd;
    logic [BANK_W-1:0]       bank;
    logic                    ap;
    logic [ROW_W-1:0]        row;
    logic                    dq_oe_n;
    logic                    dq_term;
    modport ctrl (output cke, output cs_n, output cmd, output bank, output ap, output row,
                  input dq_oe_n, input dq_term);
    modport dev  (input cke, input cs_n, input cmd, input bank, input ap, input row,
                  output dq_oe_n, output dq_term);
endinterface
`default_nettype wire

// ===== rtl/lp_mem_device.sv
// memory device end: power-state and bank-state tracking from the clock-enable level and commands
// assumes the controller keeps the link protocol; one bank state stands for the addressed bank
`timescale 1ns/1ps
`default_nettype none
module lp_mem_device
    import lp_mem_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        NRST,
    lp_mem_link_if.dev       link,
    input  wire logic        ODT_ENABLE,
    output pwr_type          POWER_STATE,
    output bank_type         BANK_STATE,
    output logic [ROW_W-1:0] OPEN_ROW
);
    pwr_type          pwr_q;
    bank_type         bank_q;
    logic             cke_prev_q;
    logic [7:0]       timer_q;
    logic [7:0]       exit_q;
    logic [7:0]       init_q;
    logic             ap_q;
    logic [ROW_W-1:0] row_q;
    logic             dq_oe_n_q;
    logic             dq_term_q;

    logic low_both;
    logic exit_edge;
    logic entry_edge;
    logic cmd_ok;
    logic in_burst;
    logic in_low;

    assign low_both   = !cke_prev_q && !link.cke;
    assign exit_edge  = !cke_prev_q && link.cke && link.cs_n;
    assign entry_edge = cke_prev_q && !link.cke;
    // both high, chip selected, and any exit wait over
    assign cmd_ok     = cke_prev_q && link.cke && !link.cs_n && (exit_q == T_ZERO);
    assign in_burst   = (bank_q == B_READ) || (bank_q == B_WRITE);
    assign in_low     = (pwr_q == P_PD_IDLE) || (pwr_q == P_SREF) || (pwr_q == P_DEEP);

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= link.cke;
        end
    end

    // exit wait; the device only blocks commands, the clock toggles are the controller's concern
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            exit_q <= T_ZERO;
        end else if (exit_edge && (pwr_q == P_SREF)) begin
            exit_q <= XSR_CYC;
        end else if (exit_edge && ((pwr_q == P_PD_ACTIVE) || (pwr_q == P_PD_IDLE) || (pwr_q == P_PD_RESET))) begin
            exit_q <= XP_CYC;
        end else if (exit_q != T_ZERO) begin
            exit_q <= exit_q - T_ONE;
        end
    end

    // initialization wait keeps running through resetting power-down
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            init_q <= T_ZERO;
        end else if (cmd_ok && (((link.cmd == C_RESET) && (pwr_q == P_OPERATING) && (bank_q == B_IDLE))
                               || ((link.cmd == C_MRW_RESET) && (pwr_q == P_POWER_ON)))) begin
            init_q <= INIT_CYC;
        end else if (init_q != T_ZERO) begin
            init_q <= init_q - T_ONE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            pwr_q <= P_POWER_ON;
        end else if (low_both) begin
            pwr_q <= pwr_q;
        end else begin
            unique case (pwr_q)
                P_PD_ACTIVE, P_PD_IDLE: begin
                    if (exit_edge) begin
                        pwr_q <= P_OPERATING;
                    end
                end
                P_PD_RESET: begin
                    if (exit_edge) begin
                        pwr_q <= (init_q == T_ZERO) ? P_OPERATING : P_RESETTING;
                    end
                end
                P_SREF: begin
                    if (exit_edge) begin
                        pwr_q <= P_OPERATING;
                    end
                end
                P_DEEP: begin
                    if (exit_edge) begin
                        pwr_q <= P_POWER_ON;
                    end
                end
                P_POWER_ON: begin
                    if (cmd_ok && (link.cmd == C_MRW_RESET)) begin
                        pwr_q <= P_RESETTING;
                    end
                end
                P_RESETTING: begin
                    if (entry_edge && link.cs_n) begin
                        pwr_q <= P_PD_RESET;
                    end else if ((init_q == T_ZERO) && (bank_q == B_IDLE)) begin
                        pwr_q <= P_OPERATING;
                    end
                end
                P_OPERATING: begin
                    if (entry_edge && link.cs_n && (bank_q == B_ACTIVE)) begin
                        pwr_q <= P_PD_ACTIVE;
                    end else if (entry_edge && link.cs_n && (bank_q == B_IDLE)) begin
                        pwr_q <= P_PD_IDLE;
                    end else if (entry_edge && !link.cs_n && (link.cmd == C_SREF) && (bank_q == B_IDLE)) begin
                        pwr_q <= P_SREF;
                    end else if (entry_edge && !link.cs_n && (link.cmd == C_DEEP) && (bank_q == B_IDLE)) begin
                        pwr_q <= P_DEEP;
                    end else if (cmd_ok && (link.cmd == C_RESET) && (bank_q == B_IDLE)) begin
                        pwr_q <= P_RESETTING;
                    end
                end
                default: pwr_q <= P_POWER_ON;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            bank_q  <= B_IDLE;
            timer_q <= T_ZERO;
            ap_q    <= 1'b0;
            row_q   <= '0;
        end else if (cmd_ok && (pwr_q == P_OPERATING) && ((timer_q == T_ZERO) || in_burst)) begin
            // timed states refuse same-bank commands; bursts accept a new read or write
            unique case (bank_q)
                B_IDLE: begin
                    if (link.cmd == C_ACTIVATE) begin
                        bank_q  <= B_ACTIVATING;
                        row_q   <= link.row;
                        timer_q <= RCD_CYC;
                    end else if (link.cmd == C_REF_PB) begin
                        bank_q  <= B_REF_PB;
                        timer_q <= RFPB_CYC;
                    end else if (link.cmd == C_REF_AB) begin
                        bank_q  <= B_REF_AB;
                        timer_q <= RFAB_CYC;
                    end else if (link.cmd == C_MRW) begin
                        bank_q  <= B_MRW;
                        timer_q <= MRW_CYC;
                    end else if (link.cmd == C_MRR) begin
                        bank_q  <= B_MRR_IDLE;
                        timer_q <= MRR_CYC;
                    end else if (link.cmd == C_PRECHARGE) begin
                        bank_q  <= B_PRECH;
                        timer_q <= RP_CYC;
                    end
                end
                B_ACTIVE: begin
                    if ((link.cmd == C_READ) || (link.cmd == C_WRITE)) begin
                        bank_q  <= (link.cmd == C_READ) ? B_READ : B_WRITE;
                        ap_q    <= link.ap;
                        timer_q <= BURST_CYC;
                    end else if (link.cmd == C_MRR) begin
                        bank_q  <= B_MRR_ACT;
                        timer_q <= MRR_CYC;
                    end else if (link.cmd == C_PRECHARGE) begin
                        bank_q  <= B_PRECH;
                        row_q   <= '0;
                        timer_q <= RP_CYC;
                    end
                end
                B_READ, B_WRITE: begin
                    if ((link.cmd == C_READ) || (link.cmd == C_WRITE)) begin
                        bank_q  <= (link.cmd == C_READ) ? B_READ : B_WRITE;
                        ap_q    <= link.ap;
                        timer_q <= BURST_CYC;
                    end else if (timer_q != T_ZERO) begin
                        timer_q <= timer_q - T_ONE;
                    end
                end
                B_ACTIVATING, B_PRECH, B_REF_PB, B_REF_AB, B_MRW, B_MRR_IDLE, B_MRR_ACT, B_MRR_RST: begin
                    bank_q <= bank_q;
                end
                default: bank_q <= B_IDLE;
            endcase
        end else if (cmd_ok && (pwr_q == P_RESETTING) && (timer_q == T_ZERO) && (link.cmd == C_MRR)) begin
            bank_q  <= B_MRR_RST;
            timer_q <= MRR_CYC;
        end else if (timer_q != T_ZERO) begin
            timer_q <= timer_q - T_ONE;
            if (timer_q == T_ONE) begin
                unique case (bank_q)
                    B_ACTIVATING, B_MRR_ACT: bank_q <= B_ACTIVE;
                    B_READ, B_WRITE: begin
                        // burst over; auto precharge runs on as a precharge
                        bank_q <= ap_q ? B_PRECH : B_ACTIVE;
                        if (ap_q) begin
                            timer_q <= RP_CYC;
                            row_q   <= '0;
                        end
                    end
                    default: bank_q <= B_IDLE;
                endcase
            end
        end
    end

    // data pins driven only during a read burst; terminated in idle power-down, self refresh and deep power-down when enabled
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            dq_oe_n_q <= 1'b1;
            dq_term_q <= 1'b0;
        end else begin
            dq_oe_n_q <= !((bank_q == B_READ) && !in_low);
            dq_term_q <= in_low && ODT_ENABLE;
        end
    end

    assign link.dq_oe_n = dq_oe_n_q;
    assign link.dq_term = dq_term_q;
    assign POWER_STATE  = pwr_q;
    assign BANK_STATE   = bank_q;
    assign OPEN_ROW     = row_q;
endmodule // lp_mem_device
`default_nettype wire

// ===== rtl/lp_mem_controller.sv
// memory controller end: turns user requests into link commands and keeps link timing
// assumes the user asks only for commands legal in the device's present state
`timescale 1ns/1ps
`default_nettype none
module lp_mem_controller
    import lp_mem_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    lp_mem_link_if.ctrl            link,
    input  wire logic              REQ_VALID,
    input  wire cmd_type           REQ_CMD,
    input  wire logic [BANK_W-1:0] REQ_BANK,
    input  wire logic              REQ_AP,
    input  wire logic [ROW_W-1:0]  REQ_ROW,
    output logic                   REQ_READY
);
    logic              cke_q;
    logic              cs_n_q;
    cmd_type           cmd_q;
    logic [BANK_W-1:0] bank_q;
    logic              ap_q;
    logic [ROW_W-1:0]  row_q;
    logic [7:0]        wait_q;
    logic              sref_q;
    logic              ready_q;
    logic              take;
    logic              low_q;

    assign take = REQ_VALID && ready_q;

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            cke_q  <= 1'b0;
            cs_n_q <= 1'b1;
            cmd_q  <= C_NOP;
            bank_q <= '0;
            ap_q   <= 1'b0;
            row_q  <= '0;
            sref_q <= 1'b0;
        end else begin
            cs_n_q <= 1'b1;
            cmd_q  <= C_NOP;
            // raised once after reset; in low power it stays low until the exit request
            if (!cke_q && !low_q && !take) begin
                cke_q <= 1'b1;
            end
            if (take) begin
                bank_q <= REQ_BANK;
                ap_q   <= REQ_AP;
                row_q  <= REQ_ROW;
                unique case (REQ_CMD)
                    C_ENTER_PD: begin
                        cke_q  <= 1'b0;
                        sref_q <= 1'b0;
                    end
                    C_SREF, C_DEEP: begin
                        cke_q  <= 1'b0;
                        cs_n_q <= 1'b0;
                        cmd_q  <= REQ_CMD;
                        sref_q <= 1'b1;
                    end
                    C_EXIT_LP: begin
                        cke_q <= 1'b1;
                    end
                    C_NOP: begin
                        cmd_q <= C_NOP;
                    end
                    default: begin
                        cs_n_q <= 1'b0;
                        cmd_q  <= REQ_CMD;
                    end
                endcase
            end
        end
    end

    // low-power states hold clock enable low until the exit request
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            low_q <= 1'b0;
        end else if (take && ((REQ_CMD == C_ENTER_PD) || (REQ_CMD == C_SREF) || (REQ_CMD == C_DEEP))) begin
            low_q <= 1'b1;
        end else if (take && (REQ_CMD == C_EXIT_LP)) begin
            low_q <= 1'b0;
        end
    end

    // only no-operation goes out while an exit wait or a timed state other than a burst or the initialization wait runs
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            wait_q  <= CLK_TOGGLES;
            ready_q <= 1'b0;
        end else if (take) begin
            ready_q <= 1'b0;
            if (REQ_CMD == C_EXIT_LP) begin
                wait_q <= CLK_TOGGLES + (sref_q ? XSR_CYC : XP_CYC);
            end else if ((REQ_CMD == C_READ || REQ_CMD == C_WRITE) && REQ_AP) begin
                wait_q <= BURST_CYC + RP_CYC;
            end else if ((REQ_CMD == C_READ) || (REQ_CMD == C_WRITE) || (REQ_CMD == C_RESET)
                         || (REQ_CMD == C_MRW_RESET)) begin
                // an open burst takes a new read or write; resetting takes mode reads and power-down
                wait_q <= T_ONE;
            end else if (cmd_cycles(REQ_CMD) != T_ZERO) begin
                wait_q <= cmd_cycles(REQ_CMD);
            end else begin
                wait_q <= T_ONE;
            end
        end else if (wait_q > T_ONE) begin
            wait_q <= wait_q - T_ONE;
        end else begin
            wait_q  <= T_ZERO;
            ready_q <= 1'b1;
        end
    end

    assign link.cke  = cke_q;
    assign link.cs_n = cs_n_q;
    assign link.cmd  = cmd_q;
    assign link.bank = bank_q;
    assign link.ap   = ap_q;
    assign link.row  = row_q;
    assign REQ_READY = ready_q;
endmodule // lp_mem_controller
`default_nettype wire

// ===== bench/lp_mem_checker.sv
// link checker: timing relations between controller and device on the shared link
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lp_mem_checker
    import lp_mem_pkg::*;
(
    input wire logic    REF_CLK,
    input wire logic    NRST,
    input wire logic    cke,
    input wire logic    cs_n,
    input wire cmd_type cmd,
    input wire logic    dq_oe_n,
    input wire logic    dq_term
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    a_cmd_one_cycle: assert property (!cs_n |=> cs_n)
        else $error("command held a second cycle");
    a_cmd_needs_high: assert property ((!cs_n && !(cmd inside {C_SREF, C_DEEP})) |-> cke && $past(cke))
        else $error("command with clock enable low");
    a_fall_by_code: assert property ($fell(cke) |-> cs_n || cmd inside {C_SREF, C_DEEP})
        else $error("clock enable fell with bad command");
    a_exit_quiet: assert property ($rose(cke) |-> cs_n [*2])
        else $error("command too soon after exit");
    a_lowpow_off: assert property ((!cke && !$past(cke)) |-> dq_oe_n)
        else $error("data driven in low power");
    a_term_on_entry: assert property ($rose(dq_term) |-> !cke && !$past(cke))
        else $error("termination outside low power");
    a_read_drives: assert property ((!cs_n && cmd == C_READ) |-> ##[1:3] !dq_oe_n)
        else $error("read burst not driven");
    a_burst_length: assert property ($fell(dq_oe_n) |-> (!dq_oe_n) [*4] ##1 dq_oe_n)
        else $error("read burst length wrong");
    a_write_silent: assert property ((!cs_n && cmd == C_WRITE) |=> dq_oe_n [*5])
        else $error("data driven during write");

    c_exit: cover property ($rose(cke));
    c_read: cover property (!cs_n && cmd == C_READ);
    c_term: cover property ($rose(dq_term));
endmodule // lp_mem_checker
`default_nettype wire

// ===== bench/dram_power_state_and_bank_fsm_bench.sv
// bench: controller and device joined by the link, user requests drive both ends
// assumes package timing constants; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module dram_power_state_and_bank_fsm_bench;
    import lp_mem_pkg::*;
    logic              ref_clk;
    logic              nrst;
    logic              odt_en;
    logic              req_valid;
    cmd_type           req_cmd;
    logic [BANK_W-1:0] req_bank;
    logic              req_ap;
    logic [ROW_W-1:0]  req_row;
    logic              req_ready;
    pwr_type           power_state;
    bank_type          bank_state;
    logic [ROW_W-1:0]  open_row;
    int                n_mismatch = 0;
    int                check_count = 0;
    int                cycles = 0;
    cmd_type           tbl_cmd [5] = '{C_MRW, C_REF_PB, C_REF_AB, C_MRR, C_PRECHARGE};
    bank_type          tbl_bank [5] = '{B_MRW, B_REF_PB, B_REF_AB, B_MRR_IDLE, B_PRECH};
    cmd_type           lp_cmd [3] = '{C_ENTER_PD, C_SREF, C_DEEP};
    pwr_type           lp_pwr [3] = '{P_PD_IDLE, P_SREF, P_DEEP};
    pwr_type           lp_exit [3] = '{P_OPERATING, P_OPERATING, P_POWER_ON};

    lp_mem_link_if link_bus ();
    lp_mem_controller i_lp_mem_controller (.REF_CLK(ref_clk), .NRST(nrst), .link(link_bus.ctrl),
        .REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_BANK(req_bank), .REQ_AP(req_ap),
        .REQ_ROW(req_row), .REQ_READY(req_ready));
    lp_mem_device i_lp_mem_device (.REF_CLK(ref_clk), .NRST(nrst), .link(link_bus.dev),
        .ODT_ENABLE(odt_en), .POWER_STATE(power_state), .BANK_STATE(bank_state), .OPEN_ROW(open_row));
    lp_mem_checker i_lp_mem_checker (.REF_CLK(ref_clk), .NRST(nrst), .cke(link_bus.cke),
        .cs_n(link_bus.cs_n), .cmd(link_bus.cmd), .dq_oe_n(link_bus.dq_oe_n), .dq_term(link_bus.dq_term));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic fail(input string msg);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    // polls so a one-cycle timed state is still seen
    task automatic chk_pwr(input pwr_type exp, input int n);
        int i;
        check_count++;
        for (i = 0; i < n && power_state !== exp; i++)
            @(negedge ref_clk);
        if (power_state !== exp)
            fail("power state");
    endtask

    task automatic chk_bank(input bank_type exp, input int n);
        int i;
        check_count++;
        for (i = 0; i < n && bank_state !== exp; i++)
            @(negedge ref_clk);
        if (bank_state !== exp)
            fail("bank state");
    endtask

    task automatic chk_val(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
        check_count++;
        if (got !== exp)
            fail("value");
    endtask

    // request held until the edge that samples ready high
    task automatic issue(input cmd_type c, input logic ap, input logic [ROW_W-1:0] row);
        int i;
        @(negedge ref_clk);
        req_cmd = c;
        req_ap = ap;
        req_row = row;
        req_bank = 3'h3;
        req_valid = 1'b1;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++)
            @(negedge ref_clk);
        if (req_ready !== 1'b1)
            fail("request not taken");
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        nrst = 1'b0;
        odt_en = 1'b0;
        req_valid = 1'b0;
        req_cmd = C_NOP;
        req_bank = 3'h0;
        req_ap = 1'b0;
        req_row = 15'h0000;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        chk_pwr(P_POWER_ON, 1);
        chk_bank(B_IDLE, 1);
        issue(C_MRW_RESET, 1'b0, 15'h0000);
        chk_pwr(P_RESETTING, 4);
        chk_pwr(P_OPERATING, 400);
        foreach (tbl_cmd[k]) begin
            issue(tbl_cmd[k], 1'b0, 15'h0000);
            chk_bank(tbl_bank[k], 4);
            chk_bank(B_IDLE, 20);
        end
        issue(C_ACTIVATE, 1'b0, 15'h5a5a);
        chk_bank(B_ACTIVATING, 4);
        chk_bank(B_ACTIVE, 4);
        chk_val(open_row, 15'h5a5a);
        issue(C_MRR, 1'b0, 15'h0000);
        chk_bank(B_MRR_ACT, 4);
        chk_bank(B_ACTIVE, 8);
        issue(C_READ, 1'b0, 15'h0000);
        chk_bank(B_READ, 4);
        chk_bank(B_ACTIVE, 8);
        issue(C_WRITE, 1'b0, 15'h0000);
        chk_bank(B_WRITE, 4);
        issue(C_WRITE, 1'b0, 15'h0000);
        repeat (3) @(negedge ref_clk);
        chk_bank(B_WRITE, 1);
        chk_bank(B_ACTIVE, 8);
        issue(C_ENTER_PD, 1'b0, 15'h0000);
        chk_pwr(P_PD_ACTIVE, 4);
        issue(C_NOP, 1'b0, 15'h0000);
        repeat (10) @(negedge ref_clk);
        chk_pwr(P_PD_ACTIVE, 1);
        issue(C_EXIT_LP, 1'b0, 15'h0000);
        chk_pwr(P_OPERATING, 6);
        chk_bank(B_ACTIVE, 1);
        issue(C_READ, 1'b1, 15'h0000);
        chk_bank(B_PRECH, 8);
        chk_bank(B_IDLE, 4);
        chk_val(open_row, 15'h0000);
        issue(C_RESET, 1'b0, 15'h0000);
        chk_pwr(P_RESETTING, 4);
        issue(C_MRR, 1'b0, 15'h0000);
        chk_bank(B_MRR_RST, 4);
        chk_bank(B_IDLE, 8);
        issue(C_ENTER_PD, 1'b0, 15'h0000);
        chk_pwr(P_PD_RESET, 4);
        issue(C_EXIT_LP, 1'b0, 15'h0000);
        chk_pwr(P_RESETTING, 4);
        chk_pwr(P_OPERATING, 400);
        for (int m = 0; m < 3; m++) begin
            odt_en = (m != 1);
            issue(lp_cmd[m], 1'b0, 15'h0000);
            chk_pwr(lp_pwr[m], 4);
            repeat (3) @(negedge ref_clk);
            chk_val(15'(link_bus.dq_term), 15'(odt_en));
            chk_val(15'(link_bus.dq_oe_n), 15'h0001);
            issue(C_EXIT_LP, 1'b0, 15'h0000);
            chk_pwr(lp_exit[m], 8);
        end
        give_verdict();
    end
endmodule // dram_power_state_and_bank_fsm_bench
`default_nettype wire
